// >>> design/rdp_parser.sv
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
`include "rdp_params.svh"

module rdp_parser
    import rdp_pkg::*;
#(
    parameter int NUM_RES = 8,
    parameter int FIFO_DEPTH = 4
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // descriptor byte stream from the demultiplexer
    input wire logic byteValid,
    output logic byteReady,
    input wire logic [7:0] byteData,
    // media-type characters to the application controller
    output logic charValid,
    input wire logic charReady,
    output logic [7:0] mediaTypeChar,
    output logic charLast,
    // acquisition result
    output logic [31:0] maxAge,
    output logic maxAgeValid,
    output logic descMalformed,
    // application control
    output logic appRunning,
    output logic appSuspend,
    output logic viewerFeedback,
    output logic ageExpired,
    // wishbone slave
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    output logic wb_ack_o
);

localparam int IW = (NUM_RES > 1) ? $clog2(NUM_RES) : 1;
localparam logic [10:0] TICK_CYCLES = 11'(`RDP_TICK_CYCLES);

function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
        if (sel[b])
            res[b*8 +: 8] = data[b*8 +: 8];
    return res;
endfunction : merge

////////////////////////////////////////////////////////////////////////////
// input buffer
logic fifoValid, fifoReady, take;
logic [7:0] fifoData;
logic [31:0] ctrl;

rdp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) inBuf (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .inValid(byteValid),
    .inReady(byteReady),
    .inData(byteData),
    .outValid(fifoValid),
    .outReady(fifoReady),
    .outData(fifoData)
);

// a pending character the consumer has not taken stalls the stream
assign fifoReady = ctrl[`RDP_CTRL_PARSE_EN] && (!charValid || charReady);
assign take = fifoValid && fifoReady;

////////////////////////////////////////////////////////////////////////////
// descriptor parser
rdp_state_type state, next_state;
rdp_kind_type kind, next_kind;
logic [7:0] remain, next_remain;
logic [31:0] acc, next_acc, next_maxAge;
logic next_charValid, next_charLast, next_maxAgeValid, next_descMalformed;
logic [7:0] next_mediaTypeChar;
logic mediaSeen, next_mediaSeen;

always_comb
begin
    next_state = state;
    next_kind = kind;
    next_remain = remain;
    next_acc = acc;
    next_maxAge = maxAge;
    next_charValid = charValid && !charReady;
    next_mediaTypeChar = mediaTypeChar;
    next_charLast = charLast;
    next_maxAgeValid = 1'b0;
    next_descMalformed = 1'b0;
    next_mediaSeen = 1'b0;
    if (take)
    begin
        unique case (state)
            ST_TAG:
            begin
                if (fifoData == `RDP_TAG_MEDIA)
                    next_kind = KIND_MEDIA;
                else if (fifoData == `RDP_TAG_ACQ)
                    next_kind = KIND_ACQ;
                else
                    next_kind = KIND_SKIP;
                next_state = ST_LEN;
            end
            ST_LEN:
            begin
                next_remain = fifoData;
                next_acc = '0;
                next_mediaSeen = (kind == KIND_MEDIA);
                if (kind == KIND_ACQ && fifoData != `RDP_ACQ_LEN)
                begin
                    // bad length: flag, then skip by stated length
                    next_descMalformed = 1'b1;
                    next_kind = KIND_SKIP;
                end
                next_state = (fifoData == 8'h00) ? ST_TAG : ST_BODY;
            end
            ST_BODY:
            begin
                if (kind == KIND_MEDIA)
                begin
                    next_charValid = 1'b1;
                    next_mediaTypeChar = fifoData;
                    next_charLast = (remain == 8'h01);
                end
                else if (kind == KIND_ACQ)
                begin
                    next_acc = {acc[23:0], fifoData};
                    if (remain == 8'h01)
                    begin
                        next_maxAge = {acc[23:0], fifoData};
                        next_maxAgeValid = 1'b1;
                    end
                end
                next_remain = remain - 8'h01;
                if (remain == 8'h01)
                    next_state = ST_TAG;
            end
        endcase
    end
end

always_ff @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        state <= ST_TAG;
        kind <= KIND_SKIP;
        remain <= 8'h00;
        acc <= 32'h0000_0000;
        maxAge <= 32'h0000_0000;
        charValid <= 1'b0;
        mediaTypeChar <= 8'h00;
        charLast <= 1'b0;
        maxAgeValid <= 1'b0;
        descMalformed <= 1'b0;
        mediaSeen <= 1'b0;
    end
    else
    begin
        state <= next_state;
        kind <= next_kind;
        remain <= next_remain;
        acc <= next_acc;
        maxAge <= next_maxAge;
        charValid <= next_charValid;
        mediaTypeChar <= next_mediaTypeChar;
        charLast <= next_charLast;
        maxAgeValid <= next_maxAgeValid;
        descMalformed <= next_descMalformed;
        mediaSeen <= next_mediaSeen;
    end
end

////////////////////////////////////////////////////////////////////////////
// acquisition deadline timer, one step per 90 kHz tick
logic [10:0] divCnt, next_divCnt;
logic [31:0] ageLeft, next_ageLeft;
logic ageArmed, next_ageArmed, tick;

assign tick = (divCnt == TICK_CYCLES - 11'h001);

always_comb
begin
    next_divCnt = tick ? 11'h000 : divCnt + 11'h001;
    next_ageLeft = ageLeft;
    next_ageArmed = ageArmed;
    if (maxAgeValid)
    begin
        // a fresh deadline restarts the count
        next_ageLeft = maxAge;
        next_ageArmed = (maxAge != 32'h0000_0000);
    end
    else if (ageArmed && tick)
    begin
        next_ageLeft = ageLeft - 32'h0000_0001;
        next_ageArmed = (ageLeft != 32'h0000_0001);
    end
end

always_ff @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        divCnt <= 11'h000;
        ageLeft <= 32'h0000_0000;
        ageArmed <= 1'b0;
    end
    else
    begin
        divCnt <= next_divCnt;
        ageLeft <= next_ageLeft;
        ageArmed <= next_ageArmed;
    end
end

////////////////////////////////////////////////////////////////////////////
// registers, access control and application start
logic [NUM_RES-1:0] resolved, meta, partial, complete, refMask;
logic [NUM_RES-1:0] next_resolved, next_meta, next_partial;
logic [NUM_RES-1:0] next_complete, next_refMask;
logic [31:0] next_ctrl, accRes, next_accRes, stat, next_wb_dat_o;
logic [7:0] stickies, next_stickies;
logic [15:0] mediaCnt, next_mediaCnt;
logic next_appRunning, next_appSuspend, next_viewerFeedback, next_ack;
logic lazy, startOk, missing, wrStb, startReq, stopReq;
logic [IW-1:0] idx;

assign lazy = ctrl[`RDP_CTRL_LAZY];
assign wrStb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
assign idx = wb_dat_i[IW-1:0];
assign missing = |(refMask & ~complete);
// conservative waits for whole bodies, lazy only for metadata
assign startOk = lazy ? &(~refMask | meta)
    : &(~refMask | complete);

always_comb
begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_ctrl = ctrl;
    next_resolved = resolved;
    next_meta = meta;
    next_partial = partial;
    next_complete = complete;
    next_refMask = refMask;
    next_accRes = accRes;
    startReq = 1'b0;
    stopReq = 1'b0;
    // cache bits change only by software; no ageing of entries
    next_stickies = stickies;
    if (wrStb)
    begin
        unique case (wb_adr_i)
            `RDP_OFS_CTRL:
            begin
                next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i) & 32'h0000_0007;
                startReq = wb_sel_i[0] && wb_dat_i[`RDP_CTRL_START];
                stopReq = wb_sel_i[0] && wb_dat_i[`RDP_CTRL_STOP];
            end
            `RDP_OFS_RESOLVED:
                next_resolved = NUM_RES'(merge(32'(resolved), wb_dat_i,
                    wb_sel_i));
            `RDP_OFS_META:
                next_meta = NUM_RES'(merge(32'(meta), wb_dat_i, wb_sel_i));
            `RDP_OFS_PARTIAL:
                next_partial = NUM_RES'(merge(32'(partial), wb_dat_i,
                    wb_sel_i));
            `RDP_OFS_COMPLETE:
                next_complete = NUM_RES'(merge(32'(complete), wb_dat_i,
                    wb_sel_i));
            `RDP_OFS_REFMASK:
                next_refMask = NUM_RES'(merge(32'(refMask), wb_dat_i,
                    wb_sel_i));
            `RDP_OFS_ACCESS:
            begin
                next_accRes = 32'h0000_0000;
                next_accRes[`RDP_ACC_INDEX +: IW] = idx;
                next_accRes[`RDP_ACC_UNRESOLVED] = !resolved[idx];
                next_accRes[`RDP_ACC_ABSENT] =
                    !(partial[idx] || complete[idx]);
                next_accRes[`RDP_ACC_GRANT] = resolved[idx]
                    && (partial[idx] || complete[idx]);
            end
            `RDP_OFS_STATUS:
                if (wb_sel_i[0])
                    next_stickies = stickies & ~wb_dat_i[7:0];
            default:
                next_ctrl = ctrl;
        endcase
    end
    // a flag raised in the clearing cycle survives
    next_stickies[`RDP_ST_MALFORMED] = next_stickies[`RDP_ST_MALFORMED]
        || descMalformed;
    next_stickies[`RDP_ST_NONASCII] = next_stickies[`RDP_ST_NONASCII]
        || (take && state == ST_BODY && kind == KIND_MEDIA
        && fifoData[7]);
    next_stickies[`RDP_ST_EXPIRED] = next_stickies[`RDP_ST_EXPIRED]
        || (ageArmed && tick && ageLeft == 32'h0000_0001);
    next_mediaCnt = mediaSeen ? mediaCnt + 16'h0001 : mediaCnt;
    // start is refused while the mode's availability test fails
    next_appRunning = appRunning ? !stopReq
        : (startReq && startOk);
    next_appSuspend = next_appRunning && lazy && missing
        && !next_ctrl[`RDP_CTRL_FEEDBACK];
    next_viewerFeedback = next_appRunning && lazy && missing
        && next_ctrl[`RDP_CTRL_FEEDBACK];
end

assign stat = {24'h00_0000, ageArmed, stickies[6:4], viewerFeedback,
    appSuspend, startOk, appRunning};
assign ageExpired = stickies[`RDP_ST_EXPIRED];

// read data is captured with the acknowledge
always_comb
begin
    unique case (wb_adr_i)
        `RDP_OFS_CTRL: next_wb_dat_o = ctrl;
        `RDP_OFS_RESOLVED: next_wb_dat_o = 32'(resolved);
        `RDP_OFS_META: next_wb_dat_o = 32'(meta);
        `RDP_OFS_PARTIAL: next_wb_dat_o = 32'(partial);
        `RDP_OFS_COMPLETE: next_wb_dat_o = 32'(complete);
        `RDP_OFS_REFMASK: next_wb_dat_o = 32'(refMask);
        `RDP_OFS_ACCESS: next_wb_dat_o = accRes;
        `RDP_OFS_STATUS: next_wb_dat_o = stat;
        `RDP_OFS_MAXAGE: next_wb_dat_o = maxAge;
        `RDP_OFS_MEDIACNT: next_wb_dat_o = {16'h0000, mediaCnt};
        default: next_wb_dat_o = 32'h0000_0000;
    endcase
end

always_ff @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
        ctrl <= `RDP_CTRL_RESET;
        resolved <= '0;
        meta <= '0;
        partial <= '0;
        complete <= '0;
        refMask <= '0;
        accRes <= 32'h0000_0000;
        stickies <= 8'h00;
        mediaCnt <= 16'h0000;
        appRunning <= 1'b0;
        appSuspend <= 1'b0;
        viewerFeedback <= 1'b0;
    end
    else
    begin
        wb_ack_o <= next_ack;
        wb_dat_o <= next_wb_dat_o;
        ctrl <= next_ctrl;
        resolved <= next_resolved;
        meta <= next_meta;
        partial <= next_partial;
        complete <= next_complete;
        refMask <= next_refMask;
        accRes <= next_accRes;
        stickies <= next_stickies;
        mediaCnt <= next_mediaCnt;
        appRunning <= next_appRunning;
        appSuspend <= next_appSuspend;
        viewerFeedback <= next_viewerFeedback;
    end
end

endmodule : rdp_parser

// >>> design/rdp_params.svh
`ifndef RDP_PARAMS_SVH
`define RDP_PARAMS_SVH

// descriptor tags and fixed lengths
`define RDP_TAG_MEDIA 8'h72
`define RDP_TAG_ACQ 8'h89
`define RDP_ACQ_LEN 8'h04

// tick timing: core clock and acquisition tick rate in Hz
`define RDP_CLK_HZ 100000000
`define RDP_TICK_HZ 90000
`define RDP_TICK_CYCLES (`RDP_CLK_HZ / `RDP_TICK_HZ)

// register byte addresses
`define RDP_OFS_CTRL 8'h00
`define RDP_OFS_RESOLVED 8'h04
`define RDP_OFS_META 8'h08
`define RDP_OFS_PARTIAL 8'h0C
`define RDP_OFS_COMPLETE 8'h10
`define RDP_OFS_REFMASK 8'h14
`define RDP_OFS_ACCESS 8'h18
`define RDP_OFS_STATUS 8'h1C
`define RDP_OFS_MAXAGE 8'h20
`define RDP_OFS_MEDIACNT 8'h24

// control fields
`define RDP_CTRL_LAZY 0
`define RDP_CTRL_FEEDBACK 1
`define RDP_CTRL_PARSE_EN 2
`define RDP_CTRL_START 3
`define RDP_CTRL_STOP 4
`define RDP_CTRL_RESET 32'h0000_0004

// access result fields
`define RDP_ACC_GRANT 0
`define RDP_ACC_UNRESOLVED 1
`define RDP_ACC_ABSENT 2
`define RDP_ACC_INDEX 8

// status fields
`define RDP_ST_RUNNING 0
`define RDP_ST_START_OK 1
`define RDP_ST_SUSPEND 2
`define RDP_ST_FEEDBACK 3
`define RDP_ST_MALFORMED 4
`define RDP_ST_NONASCII 5
`define RDP_ST_EXPIRED 6
`define RDP_ST_ARMED 7

`endif

// >>> design/rdp_pkg.sv
package rdp_pkg;

    // parser position inside one descriptor
    typedef enum logic [1:0] {ST_TAG, ST_LEN, ST_BODY} rdp_state_type;

    // what the body bytes are used for
    typedef enum logic [1:0] {KIND_SKIP, KIND_MEDIA, KIND_ACQ} rdp_kind_type;

endpackage : rdp_pkg

// >>> design/rdp_fifo.sv
`timescale 1ns/1ps

module rdp_fifo
    import rdp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

logic [WIDTH-1:0] store [DEPTH];
logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
logic [AW:0] count, next_count;
logic push, pop;

////////////////////////////////////////////////////////////////////////////
// handshake and pointer update
assign inReady = (count != (AW + 1)'(DEPTH));
assign outValid = (count != '0);
assign outData = store[rdPtr];
assign push = inValid && inReady;
assign pop = outValid && outReady;

always_comb
begin
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    // pointers wrap at depth, which need not be a power of two
    if (push)
        next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : AW'(wrPtr + 1'b1);
    if (pop)
        next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : AW'(rdPtr + 1'b1);
    next_count = count;
    if (push && !pop)
        next_count = (AW + 1)'(count + 1'b1);
    else if (pop && !push)
        next_count = (AW + 1)'(count - 1'b1);
end

always_ff @(posedge core_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        wrPtr <= '0;
        rdPtr <= '0;
        count <= '0;
    end
    else
    begin
        wrPtr <= next_wrPtr;
        rdPtr <= next_rdPtr;
        count <= next_count;
    end
end

// storage has no reset; nothing reads a slot before it is written
always_ff @(posedge core_clk)
begin
    if (push)
        store[wrPtr] <= inData;
end

endmodule : rdp_fifo

// >>> verif/rdp_byte_source.sv
`timescale 1ns/1ps

module rdp_byte_source (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // descriptor byte stream
    input wire logic byteReady,
    output logic byteValid = 1'b0,
    output logic [7:0] byteData = 8'hA5
);
    logic [7:0] q[$];
    logic slow = 1'b0;

    ////////////////////////////////
    // offer oldest byte, hold it until taken; idle data toggles so a
    // parser that samples an idle bus never sees the old byte two cycles in a row
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            byteValid <= 1'b0;
            byteData <= ~byteData;
        end
        else
        begin
            if (byteValid && byteReady)
                void'(q.pop_front());
            // slow mode leaves a gap after every byte taken
            if (q.size() == 0 || (slow && byteValid && byteReady))
            begin
                byteValid <= 1'b0;
                byteData <= ~byteData;
            end
            else
            begin
                byteValid <= 1'b1;
                byteData <= q[0];
            end
        end
    end
endmodule : rdp_byte_source

// >>> verif/rdp_parser_monitor.sv
`timescale 1ns/1ps

module rdp_parser_monitor (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // stream outputs
    input wire logic charValid,
    input wire logic charReady,
    input wire logic [7:0] mediaTypeChar,
    input wire logic charLast,
    input wire logic [31:0] maxAge,
    input wire logic maxAgeValid,
    input wire logic descMalformed,
    // application control
    input wire logic appRunning,
    input wire logic appSuspend,
    input wire logic viewerFeedback,
    // bus
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_stb_i,
    input wire logic wb_cyc_i,
    input wire logic wb_ack_o
);
    logic startWr;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // start request taken on the control register, lane 0
    assign startWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
        wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[3];

    ////////////////////////////////
    AST_ACK_NEXT: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack missing or longer than one cycle");
    AST_AGE_CAUSE: assert property (
        $changed(maxAge) |-> maxAgeValid)
        else $error("deadline changed without valid pulse");
    AST_AGE_PULSE: assert property (
        maxAgeValid |=> !maxAgeValid)
        else $error("deadline valid longer than one cycle");
    AST_MALF_PULSE: assert property (
        descMalformed |-> !maxAgeValid ##1 !descMalformed)
        else $error("malformed pulse wrong");
    AST_SUSP_RUN: assert property (
        appSuspend || viewerFeedback |-> appRunning)
        else $error("suspend or feedback while stopped");
    AST_SUSP_EXCL: assert property (
        !(appSuspend && viewerFeedback))
        else $error("suspend and feedback together");
    AST_CHAR_HOLD: assert property (
        charValid && !charReady |=>
        charValid && $stable({charLast, mediaTypeChar}))
        else $error("char dropped before taken");
    AST_START_CAUSE: assert property (
        $rose(appRunning) |-> $past(startWr) || $past(startWr, 2))
        else $error("application started without request");
endmodule : rdp_parser_monitor

bind rdp_parser rdp_parser_monitor mon (.core_clk, .reset_n, .charValid,
    .charReady, .mediaTypeChar, .charLast, .maxAge, .maxAgeValid,
    .descMalformed, .appRunning, .appSuspend, .viewerFeedback, .wb_adr_i,
    .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o);

// >>> verif/resource_descriptor_parser_tb.sv
`timescale 1ns/1ps

module resource_descriptor_parser_tb;
    logic core_clk = 0;
    logic reset_n = 0;
    logic byteValid, byteReady, charValid, charLast, maxAgeValid;
    logic [7:0] byteData, mediaTypeChar;
    logic charReady = 0;
    logic [31:0] maxAge, wb_dat_o;
    logic descMalformed, appRunning, appSuspend, viewerFeedback;
    logic ageExpired, wb_ack_o;
    logic [7:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0;
    logic [31:0] expRd[$], expAge[$];
    logic [8:0] expChr[$];
    logic [31:0] acc[3] = '{32'h0000_0001, 32'h0000_0104, 32'h0000_0202};
    int errors = 0, check_count = 0, cycles = 0, malCnt = 0;
    integer seed = 35;

    always #5 core_clk = ~core_clk;

    rdp_byte_source src (.core_clk, .reset_n, .byteReady, .byteValid,
        .byteData);
    rdp_parser #(.NUM_RES(8), .FIFO_DEPTH(4)) dut (.core_clk, .reset_n,
        .byteValid, .byteReady, .byteData, .charValid, .charReady,
        .mediaTypeChar, .charLast, .maxAge, .maxAgeValid, .descMalformed,
        .appRunning, .appSuspend, .viewerFeedback, .ageExpired, .wb_adr_i,
        .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i,
        .wb_ack_o);

    ////////////////////////////////
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            errors++;
        end
    endtask : chk

    task stop_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    // single classic cycle; released only at the edge that saw ack
    // no wait limit of its own: only the bench timeout ends a hung cycle
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, 4'hF};
        do
            @(posedge core_clk);
        while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] e);
        expRd.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask : rd

    task media(input int n);
        logic [7:0] c;
        src.q.push_back(8'h72);
        src.q.push_back(8'(n));
        for (int i = 0; i < n; i++)
        begin
            c = 8'h61 + 8'($random(seed) & 15);
            src.q.push_back(c);
            expChr.push_back({i == n - 1, c});
        end
    endtask : media

    // payload most significant byte first, len bytes of it
    task acq(input logic [7:0] len, input logic [31:0] v);
        src.q.push_back(8'h89);
        src.q.push_back(len);
        for (int i = int'(len) - 1; i >= 0; i--)
            src.q.push_back(v[i*8 +: 8]);
        if (len == 8'h04)
            expAge.push_back(v);
    endtask : acq

    task drain;
        int n;
        n = 0;
        while ((src.q.size() + expChr.size() + expAge.size()) != 0 && n < 900)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("pending", 32'h0,
            32'(src.q.size() + expChr.size() + expAge.size()));
    endtask : drain

    // levels are registered behind the bus write, so let them land
    task app(input logic [2:0] e);
        repeat (3) @(posedge core_clk);
        chk("app", 32'(e), {29'h0, appRunning, appSuspend, viewerFeedback});
    endtask : app

    ////////////////////////////////
    // consumer stalls at random
    always @(posedge core_clk)
        charReady <= 1'($random(seed));

    // compare each result against the oldest note
    always @(posedge core_clk)
    begin
        cycles++;
        if (wb_ack_o && !wb_we_i)
            chk("rdata", expRd.pop_front(), wb_dat_o);
        if (charValid && charReady)
            chk("char", 32'(expChr.pop_front()), {23'h0, charLast,
                mediaTypeChar});
        if (maxAgeValid)
            chk("maxAge", expAge.pop_front(), maxAge);
        if (descMalformed)
            malCnt++;
        if (cycles == 20000)
        begin
            errors++;
            stop_test();
        end
    end

    ////////////////////////////////
    initial
    begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(8'h00, 32'h0000_0004);
        rd(8'h30, 32'h0);
        $display("test registers done");
        // slow source first, then back to back bytes
        src.slow = 1'b1;
        media(3);
        acq(8'h04, 32'h1122_3344);
        src.q = {src.q, 8'h55, 8'h02, 8'h72, 8'h89};
        acq(8'h02, 32'hDEAD_BEEF);
        media(1);
        drain();
        src.slow = 1'b0;
        media(5);
        acq(8'h04, 32'($random(seed)));
        drain();
        chk("malformed", 32'h1, 32'(malCnt));
        // short deadline: two ticks expire within 2222 cycles of the load
        acq(8'h04, 32'h0000_0002);
        drain();
        wb(1'b1, 8'h1C, 32'h40);
        chk("expired", 32'h0, 32'(ageExpired));
        repeat (2300) @(posedge core_clk);
        chk("expired", 32'h1, 32'(ageExpired));
        $display("test parsing done");
        // parsing off: buffer fills and refuses
        wb(1'b1, 8'h00, 32'h0);
        media(6);
        repeat (12) @(posedge core_clk);
        chk("ready", 32'h0, 32'(byteReady));
        chk("left", 32'h4, 32'(src.q.size()));
        wb(1'b1, 8'h00, 32'h4);
        drain();
        // four media descriptors seen so far, last deadline two ticks
        rd(8'h24, 32'h0000_0004);
        rd(8'h20, 32'h0000_0002);
        $display("test buffer done");
        // cache state: res0 usable, res1 absent, res2 unresolved
        wb(1'b1, 8'h14, 32'h3);
        wb(1'b1, 8'h04, 32'h3);
        wb(1'b1, 8'h0C, 32'h5);
        wb(1'b1, 8'h08, 32'h1);
        wb(1'b1, 8'h10, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, 8'h18, 32'(i));
            rd(8'h18, acc[i]);
        end
        wb(1'b1, 8'h00, 32'hC);
        app(3'b000);
        wb(1'b1, 8'h00, 32'hD);
        app(3'b000);
        wb(1'b1, 8'h08, 32'h3);
        wb(1'b1, 8'h00, 32'hD);
        app(3'b110);
        wb(1'b1, 8'h00, 32'h15);
        wb(1'b1, 8'h00, 32'hF);
        app(3'b101);
        wb(1'b1, 8'h10, 32'h3);
        app(3'b100);
        wb(1'b1, 8'h00, 32'h14);
        wb(1'b1, 8'h00, 32'hC);
        app(3'b100);
        // running, start allowed, malformed and expired flags held
        rd(8'h1C, 32'h0000_0053);
        wb(1'b1, 8'h1C, 32'h70);
        rd(8'h1C, 32'h0000_0003);
        $display("test access done");
        stop_test();
    end
endmodule : resource_descriptor_parser_tb
